/* File: rtl/port_pin_direction_drive_control.sv */
`timescale 1ns/1ps
`include "port_ctl_regs.svh"
// Overview of operation
// - with an enable term defined, pin drives if direction or term is one
// - with no enable term, direction bit alone selects output or input
// - port D direction uses only its three low bits
// - drive-select bit one makes an open-drain pin open drain
// - drive-select bit one selects fast slew on slew-capable pins
// - port B bits 7..4 open drain, bits 3..0 slew
// - port C all eight bits are open-drain selects
// - port D bits 2..0 slew, bits 7..3 no function
// - first macrocell group to port B only; second group to B or C
// - B and C inputs via input macrocells; D inputs go direct
// - three chip selects on port D, one term each, polarity set
// - chip select driver enabled by enable term or direction bit
// - port D chip selects use no output macrocell
// - port D pin one may clock the output macrocell flip-flops
// - chip select input high puts registers in standby
// - output pin follows data-out; input pin readable via data-in
// - configuration registers clear to zero, all pins input
module port_pin_direction_drive_control
   import port_ctl_pkg::*;
(
   // clock and reset
   input  wire logic                   I_MCLK,
   input  wire logic                   I_RST_N,
   // host register port
   input  wire logic [`PC_ADDR_W-1:0]  I_ADDR,
   input  wire logic                   I_WR,
   input  wire logic                   I_RD,
   input  wire logic [7:0]             I_WDATA,
   output logic      [7:0]             O_RDATA,
   // logic array terms and macrocells
   input  wire logic [7:0]             I_MC_FIRST,
   input  wire logic [7:0]             I_MC_SECOND,
   input  wire logic [7:0]             I_B_SEL_FIRST,
   input  wire logic [7:0]             I_B_SEL_SECOND,
   input  wire logic [7:0]             I_C_SEL_SECOND,
   input  wire logic [7:0]             I_OE_PT_B,
   input  wire logic [7:0]             I_OE_PT_C,
   input  wire logic [2:0]             I_OE_PT_D,
   input  wire logic [7:0]             I_OE_DEF_B,
   input  wire logic [7:0]             I_OE_DEF_C,
   input  wire logic [2:0]             I_OE_DEF_D,
   input  wire logic [2:0]             I_ECS_PT,
   input  wire logic [2:0]             I_ECS_EN,
   input  wire logic [2:0]             I_ECS_POL,
   input  wire logic [7:0]             I_IMC_CLK_B,
   input  wire logic [7:0]             I_IMC_CLK_C,
   input  wire logic                   I_CLK_IN_EN,
   input  wire logic                   I_CSI_EN,
   // pins
   input  wire logic [7:0]             I_PB_IN,
   input  wire logic [7:0]             I_PC_IN,
   input  wire logic [2:0]             I_PD_IN,
   output logic      [7:0]             O_PB_OUT,
   output logic      [7:0]             O_PB_OE_N,
   output logic      [7:0]             O_PC_OUT,
   output logic      [7:0]             O_PC_OE_N,
   output logic      [2:0]             O_PD_OUT,
   output logic      [2:0]             O_PD_OE_N,
   // driver controls and array side
   output logic      [3:0]             O_PB_FAST_SLEW,
   output logic      [2:0]             O_PD_FAST_SLEW,
   output logic      [7:0]             O_IMC_B,
   output logic      [7:0]             O_IMC_C,
   output logic      [2:0]             O_PD_DIRECT,
   output logic                        O_MC_CLK_EN,
   output logic                        O_STANDBY
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      byte_t dout_b;
      byte_t dout_c;
      dpin_t dout_d;
      byte_t dir_b;
      byte_t dir_c;
      dpin_t dir_d;
      byte_t drv_b;
      byte_t drv_c;
      dpin_t drv_d;
      byte_t imc_b;
      byte_t imc_c;
      dpin_t pd_direct;
      byte_t rdata;
      logic  clk_prev;
      logic  mc_clk_en;
      logic  standby;
      logic  [3:0] slew_b;
      dpin_t slew_d;
   } st_s;

   st_s st_r, st_nxt;
   logic        csi_hi;
   logic        reg_ok;
   logic [7:0]  sel_b;
   logic [7:0]  data_b;
   logic [2:0]  ecs_val;
   logic [2:0]  d_oe_def;
   logic [2:0]  d_plc;

   function automatic byte_t rd_mux(input logic [`PC_ADDR_W-1:0] a, input st_s s,
                                    input logic [7:0] pb, input logic [7:0] pc,
                                    input logic [2:0] pd, input logic [7:0] mo);
      byte_t r;
      r = `PC_RST_BYTE;
      unique case (a)
         `PC_IDX_DIN_B:  r = pb;
         `PC_IDX_DIN_C:  r = pc;
         `PC_IDX_DIN_D:  r = {5'h00, pd};
         `PC_IDX_DOUT_B: r = s.dout_b;
         `PC_IDX_DOUT_C: r = s.dout_c;
         `PC_IDX_DOUT_D: r = {5'h00, s.dout_d};
         `PC_IDX_DIR_B:  r = s.dir_b;
         `PC_IDX_DIR_C:  r = s.dir_c;
         `PC_IDX_DIR_D:  r = {5'h00, s.dir_d};
         `PC_IDX_DRV_B:  r = s.drv_b;
         `PC_IDX_DRV_C:  r = s.drv_c;
         `PC_IDX_DRV_D:  r = {5'h00, s.drv_d};
         `PC_IDX_MC_OUT: r = mo;
         `PC_IDX_MC_IN:  r = s.imc_b;
         default:        r = `PC_RST_BYTE;
      endcase
      return r;
   endfunction : rd_mux

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      csi_hi = I_CSI_EN & I_PD_IN[`PC_D_CSI_BIT];
      reg_ok = ~csi_hi;
      st_nxt.standby = csi_hi;
      if (reg_ok && I_WR)
      begin
         unique case (I_ADDR)
            `PC_IDX_DOUT_B: st_nxt.dout_b = I_WDATA;
            `PC_IDX_DOUT_C: st_nxt.dout_c = I_WDATA;
            `PC_IDX_DOUT_D: st_nxt.dout_d = I_WDATA[`PC_D_LO:0];
            `PC_IDX_DIR_B:  st_nxt.dir_b  = I_WDATA;
            `PC_IDX_DIR_C:  st_nxt.dir_c  = I_WDATA;
            `PC_IDX_DIR_D:  st_nxt.dir_d  = I_WDATA[`PC_D_LO:0];
            `PC_IDX_DRV_B:  st_nxt.drv_b  = I_WDATA;
            `PC_IDX_DRV_C:  st_nxt.drv_c  = I_WDATA;
            `PC_IDX_DRV_D:  st_nxt.drv_d  = I_WDATA[`PC_D_LO:0];
            default:        ;
         endcase
      end
      if (reg_ok && I_RD)
         st_nxt.rdata = rd_mux(I_ADDR, st_r, I_PB_IN, I_PC_IN, I_PD_IN,
                               I_MC_SECOND);
      // input macrocells: registered on their clock term, else hold
      for (int i = 0; i < 8; i++)
      begin
         if (I_IMC_CLK_B[i])
            st_nxt.imc_b[i] = I_PB_IN[i];
         if (I_IMC_CLK_C[i])
            st_nxt.imc_c[i] = I_PC_IN[i];
      end
      st_nxt.pd_direct = I_PD_IN;
      // clock pin edge gives macrocell enable pulse
      st_nxt.clk_prev  = I_PD_IN[`PC_D_CLK_BIT];
      st_nxt.mc_clk_en = I_CLK_IN_EN & I_PD_IN[`PC_D_CLK_BIT] & ~st_r.clk_prev;
      st_nxt.slew_b = 4'(st_r.drv_b & `PC_DRV_B_SLEW_MASK);
      st_nxt.slew_d = 3'({5'h00, st_r.drv_d} & `PC_DRV_D_SLEW_MASK);
   end

   always_ff @(posedge I_MCLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   // ----------------------------------------------------------------
   // output routing
   // ----------------------------------------------------------------
   always_comb
   begin
      sel_b  = I_B_SEL_FIRST | I_B_SEL_SECOND;
      // first group wins on port B; C gets second group only
      data_b = (I_B_SEL_FIRST & I_MC_FIRST) | (~I_B_SEL_FIRST & I_MC_SECOND);
      for (int k = 0; k < `PC_NUM_ECS; k++)
         ecs_val[k] = (ecs_pol_e'(I_ECS_POL[k]) == ECS_ACT_LOW) ? ~I_ECS_PT[k]
                                                                 : I_ECS_PT[k];
      d_plc    = I_ECS_EN;
      d_oe_def = I_OE_DEF_D;
   end

   port_pin_drive #(.W(8)) u_drv_b (
      .i_clk      (I_MCLK),
      .i_rst_n    (I_RST_N),
      .i_dir      (st_r.dir_b),
      .i_oe_pt    (I_OE_PT_B),
      .i_oe_def   (I_OE_DEF_B),
      .i_plc_sel  (sel_b),
      .i_plc_data (data_b),
      .i_dout     (st_r.dout_b),
      .i_od       (st_r.drv_b & `PC_DRV_B_OD_MASK),
      .o_pin_out  (O_PB_OUT),
      .o_pin_oe_n (O_PB_OE_N)
   );

   port_pin_drive #(.W(8)) u_drv_c (
      .i_clk      (I_MCLK),
      .i_rst_n    (I_RST_N),
      .i_dir      (st_r.dir_c),
      .i_oe_pt    (I_OE_PT_C),
      .i_oe_def   (I_OE_DEF_C),
      .i_plc_sel  (I_C_SEL_SECOND),
      .i_plc_data (I_MC_SECOND),
      .i_dout     (st_r.dout_c),
      .i_od       (st_r.drv_c & `PC_DRV_C_OD_MASK),
      .o_pin_out  (O_PC_OUT),
      .o_pin_oe_n (O_PC_OE_N)
   );

   port_pin_drive #(.W(3)) u_drv_d (
      .i_clk      (I_MCLK),
      .i_rst_n    (I_RST_N),
      .i_dir      (st_r.dir_d),
      .i_oe_pt    (I_OE_PT_D),
      .i_oe_def   (d_oe_def),
      .i_plc_sel  (d_plc),
      .i_plc_data (ecs_val),
      .i_dout     (st_r.dout_d),
      .i_od       (`PC_RST_D),
      .o_pin_out  (O_PD_OUT),
      .o_pin_oe_n (O_PD_OE_N)
   );

   assign O_RDATA        = st_r.rdata;
   assign O_PB_FAST_SLEW = st_r.slew_b;
   assign O_PD_FAST_SLEW = st_r.slew_d;
   assign O_IMC_B        = st_r.imc_b;
   assign O_IMC_C        = st_r.imc_c;
   assign O_PD_DIRECT    = st_r.pd_direct;
   assign O_MC_CLK_EN    = st_r.mc_clk_en;
   assign O_STANDBY      = st_r.standby;
endmodule : port_pin_direction_drive_control

/* File: rtl/port_ctl_regs.svh */
`ifndef PORT_CTL_REGS_SVH
`define PORT_CTL_REGS_SVH

// register indices on the host register port
`define PC_ADDR_W         5
`define PC_IDX_DIN_B      5'h00
`define PC_IDX_DIN_C      5'h01
`define PC_IDX_DIN_D      5'h02
`define PC_IDX_DOUT_B     5'h04
`define PC_IDX_DOUT_C     5'h05
`define PC_IDX_DOUT_D     5'h06
`define PC_IDX_DIR_B      5'h08
`define PC_IDX_DIR_C      5'h09
`define PC_IDX_DIR_D      5'h0a
`define PC_IDX_DRV_B      5'h0c
`define PC_IDX_DRV_C      5'h0d
`define PC_IDX_DRV_D      5'h0e
`define PC_IDX_MC_OUT     5'h10
`define PC_IDX_MC_IN      5'h11

// reset values and field masks
`define PC_RST_BYTE       8'h00
`define PC_RST_D          3'h0
`define PC_DRV_B_OD_MASK  8'hf0
`define PC_DRV_B_SLEW_MASK 8'h0f
`define PC_DRV_C_OD_MASK  8'hff
`define PC_DRV_D_SLEW_MASK 8'h07
`define PC_D_LO           2
`define PC_D_CLK_BIT      1
`define PC_D_CSI_BIT      2
`define PC_NUM_ECS        3

`endif

/* File: rtl/port_ctl_pkg.sv */
package port_ctl_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [2:0] dpin_t;
   typedef enum logic {ECS_ACT_HIGH, ECS_ACT_LOW} ecs_pol_e;
endpackage : port_ctl_pkg

/* File: rtl/port_pin_drive.sv */
`timescale 1ns/1ps
`include "port_ctl_regs.svh"
// per-pin driver: direction, data select, open-drain
module port_pin_drive
   import port_ctl_pkg::*;
#(
   parameter int W = 8
)(
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic [W-1:0] i_dir,
   input  wire logic [W-1:0] i_oe_pt,
   input  wire logic [W-1:0] i_oe_def,
   input  wire logic [W-1:0] i_plc_sel,
   input  wire logic [W-1:0] i_plc_data,
   input  wire logic [W-1:0] i_dout,
   input  wire logic [W-1:0] i_od,
   output logic      [W-1:0] o_pin_out,
   output logic      [W-1:0] o_pin_oe_n
);
   typedef struct packed {
      logic [W-1:0] out;
      logic [W-1:0] oe_n;
   } pd_s;
   pd_s s_r, s_nxt;
   logic drive;
   logic data;

   always_comb
   begin
      s_nxt = s_r;
      drive = 1'b0;
      data  = 1'b0;
      for (int i = 0; i < W; i++)
      begin
         // term defined: or of both; else direction alone
         drive = i_oe_def[i] ? (i_dir[i] | i_oe_pt[i]) : i_dir[i];
         data  = i_plc_sel[i] ? i_plc_data[i] : i_dout[i];
         s_nxt.out[i] = i_od[i] ? 1'b0 : data;
         s_nxt.oe_n[i] = ~(drive & ~(i_od[i] & data));
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         s_r <= '{out: '0, oe_n: '1};
      else
         s_r <= s_nxt;
   end

   assign o_pin_out  = s_r.out;
   assign o_pin_oe_n = s_r.oe_n;
endmodule : port_pin_drive

/* File: testbench/pin_partner.sv */
`timescale 1ns/1ps
// ----
// outside devices and pull-ups on one port
// ----
module pin_partner #(
   parameter int W = 8
)(
   input  wire logic [W-1:0] i_out,
   input  wire logic [W-1:0] i_oe_n,
   input  wire logic [W-1:0] i_ext,
   input  wire logic [W-1:0] i_ext_en,
   output logic      [W-1:0] o_lvl
);
   // released and undriven lines float up
   always_comb
   begin
      for (int k = 0; k < W; k++)
         o_lvl[k] = !i_oe_n[k] ? i_out[k] : (i_ext_en[k] ? i_ext[k] : 1'b1);
   end
endmodule : pin_partner

/* File: testbench/port_ctl_assertions.sv */
`timescale 1ns/1ps
module port_ctl_checker (
   input wire logic       I_MCLK, I_RST_N, I_RD, I_CSI_EN, I_CLK_IN_EN,
   input wire logic       O_MC_CLK_EN, O_STANDBY,
   input wire logic [7:0] O_RDATA, I_IMC_CLK_B, I_PB_IN, O_IMC_B,
   input wire logic [7:0] I_B_SEL_FIRST, I_MC_FIRST, O_PB_OUT,
   input wire logic [2:0] I_PD_IN, O_PD_DIRECT, I_OE_DEF_D, I_OE_PT_D,
   input wire logic [2:0] O_PD_OE_N, I_ECS_PT, I_ECS_POL, I_ECS_EN, O_PD_OUT
);
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_RST_N);
   wire logic       csi_hi = I_CSI_EN & I_PD_IN[2];
   wire logic [2:0] ecs_v  = (I_ECS_PT ^ I_ECS_POL) & I_ECS_EN;
   wire logic [2:0] oe_d   = I_OE_DEF_D & I_OE_PT_D;
   wire logic [7:0] fst_b  = I_B_SEL_FIRST & I_MC_FIRST & 8'h0f;
   wire logic [7:0] imc_nx = (I_IMC_CLK_B & I_PB_IN) | (~I_IMC_CLK_B & O_IMC_B);
   sequence s_d1_rise;
      I_CLK_IN_EN && $rose(I_PD_IN[1]);
   endsequence
   sequence s_pulse;
      ##[1:3] O_MC_CLK_EN;
   endsequence
   property p_pd_direct; $past(I_RST_N) |-> O_PD_DIRECT == $past(I_PD_IN); endproperty
   property p_imc_b; $past(I_RST_N) |-> O_IMC_B == $past(imc_nx); endproperty
   property p_standby; $past(I_RST_N) |-> O_STANDBY == $past(csi_hi); endproperty
   property p_clk_rise; s_d1_rise |-> s_pulse; endproperty
   property p_clk_once; O_MC_CLK_EN |=> !O_MC_CLK_EN; endproperty
   property p_pd_oe; $past(I_RST_N) |-> (~O_PD_OE_N & $past(oe_d)) == $past(oe_d); endproperty
   property p_ecs; $past(I_RST_N) |-> (O_PD_OUT & $past(I_ECS_EN)) == $past(ecs_v); endproperty
   property p_b_first;
      $past(I_RST_N) |-> (O_PB_OUT & $past(I_B_SEL_FIRST) & 8'h0f) == $past(fst_b);
   endproperty
   property p_rdata_hold; !$past(I_RD) |-> $stable(O_RDATA); endproperty
   a_pd_direct: assert property (p_pd_direct) else $error("port d direct input wrong");
   a_imc_b: assert property (p_imc_b) else $error("input macrocell capture wrong");
   a_standby: assert property (p_standby) else $error("standby flag wrong");
   a_clk_rise: assert property (p_clk_rise) else $error("no macrocell clock pulse");
   a_clk_once: assert property (p_clk_once) else $error("clock pulse too long");
   a_pd_oe: assert property (p_pd_oe) else $error("port d term enable lost");
   a_ecs: assert property (p_ecs) else $error("chip select value wrong");
   a_b_first: assert property (p_b_first) else $error("first group not on port b");
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule : port_ctl_checker

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`include "port_ctl_regs.svh"
module testbench;
   logic       clk, rst_n, wr, rd, cken, csen, mce, stb;
   logic [4:0] addr;
   logic [7:0] wdata, mcf, mcs, bsf, bss, css, ptb, ptc, dfb, dfc, ickb, ickc, xb, xbe, xc, xce;
   logic [7:0] rdata, pb, pc, pbo, pbe, pco, pce, imb, input_macrocell;
   logic [2:0] ptd, dfd, ecp, ece, ecl, xd, xde, pd, pdo, pde, sld, pdd;
   logic [3:0] slb;
   int         errors, num_checks;
   port_pin_direction_drive_control i_dut (.I_MCLK(clk), .I_RST_N(rst_n), .I_ADDR(addr),
      .I_WR(wr), .I_RD(rd), .I_WDATA(wdata), .O_RDATA(rdata), .I_MC_FIRST(mcf),
      .I_MC_SECOND(mcs), .I_B_SEL_FIRST(bsf), .I_B_SEL_SECOND(bss), .I_C_SEL_SECOND(css),
      .I_OE_PT_B(ptb), .I_OE_PT_C(ptc), .I_OE_PT_D(ptd), .I_OE_DEF_B(dfb), .I_OE_DEF_C(dfc),
      .I_OE_DEF_D(dfd), .I_ECS_PT(ecp), .I_ECS_EN(ece), .I_ECS_POL(ecl), .I_IMC_CLK_B(ickb),
      .I_IMC_CLK_C(ickc), .I_CLK_IN_EN(cken), .I_CSI_EN(csen), .I_PB_IN(pb), .I_PC_IN(pc),
      .I_PD_IN(pd), .O_PB_OUT(pbo), .O_PB_OE_N(pbe), .O_PC_OUT(pco), .O_PC_OE_N(pce),
      .O_PD_OUT(pdo), .O_PD_OE_N(pde), .O_PB_FAST_SLEW(slb), .O_PD_FAST_SLEW(sld),
      .O_IMC_B(imb), .O_IMC_C(input_macrocell), .O_PD_DIRECT(pdd), .O_MC_CLK_EN(mce), .O_STANDBY(stb));
   pin_partner #(.W(8)) i_pb (.i_out(pbo), .i_oe_n(pbe), .i_ext(xb), .i_ext_en(xbe), .o_lvl(pb));
   pin_partner #(.W(8)) i_pc (.i_out(pco), .i_oe_n(pce), .i_ext(xc), .i_ext_en(xce), .o_lvl(pc));
   pin_partner #(.W(3)) i_pd (.i_out(pdo), .i_oe_n(pde), .i_ext(xd), .i_ext_en(xde), .o_lvl(pd));
   // ----
   // host access and checking
   // ----
   task automatic w(input int n);
      repeat (n) @(negedge clk);
   endtask : w
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e)
      begin
         errors++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, s, e);
      end
   endtask : chk
   task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
      @(negedge clk);
      {addr, wdata, wr} = {a, d, 1'b1};
      @(negedge clk);
      wr = 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [4:0] a, input logic [7:0] e);
      @(negedge clk);
      {addr, rd} = {a, 1'b1};
      @(negedge clk);
      rd = 1'b0;
      chk(rdata, e);
   endtask : rd_reg
   task automatic summarize;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial
   begin
      #200us;
      errors++;
      summarize();
   end
   // ----
   // scenarios
   // ----
   initial
   begin
      {addr, wdata, mcf, mcs, bsf, bss, css, ptb, ptc, dfb, dfc, ickb, ickc} = '0;
      {xb, xbe, xc, xce, wr, rd, ptd, dfd, ecp, ece, ecl, xd, xde, cken, csen} = '0;
      rst_n = 1'b0;
      w(20);
      rst_n = 1'b1;
      w(2);
      chk(pbe, 8'hff);
      chk(pce, 8'hff);
      rd_reg(`PC_IDX_DIR_B, 8'h00);
      rd_reg(`PC_IDX_DRV_C, 8'h00);
      rd_reg(5'h1f, 8'h00);
      dfb = 8'h01;
      for (int i = 0; i < 4; i++)
      begin
         wr_reg(`PC_IDX_DIR_B, {7'h0, i[1]});
         ptb = {7'h0, i[0]};
         w(2);
         chk(pbe[0], !(i[1] | i[0]));
      end
      wr_reg(`PC_IDX_DIR_B, 8'h00);
      dfb = 8'h00;
      w(2);
      chk(pbe[0], 1'b1);
      {xb, xbe} = {8'ha0, 8'hf0};
      wr_reg(`PC_IDX_DOUT_B, 8'h05);
      wr_reg(`PC_IDX_DIR_B, 8'h0f);
      w(2);
      chk(pbe, 8'hf0);
      rd_reg(`PC_IDX_DIN_B, 8'ha5);
      wr_reg(`PC_IDX_DRV_B, 8'h5a);
      wr_reg(`PC_IDX_DIR_B, 8'hff);
      wr_reg(`PC_IDX_DOUT_B, 8'h30);
      w(2);
      rd_reg(`PC_IDX_DRV_B, 8'h5a);
      chk(slb, 4'ha);
      chk(pbe, 8'h10);
      {bsf, bss, mcf, mcs, css} = {8'h0f, 8'hff, 8'h09, 8'h60, 8'hff};
      wr_reg(`PC_IDX_DRV_B, 8'h00);
      wr_reg(`PC_IDX_DIR_C, 8'hff);
      w(2);
      chk(pbo, 8'h69);
      chk(pco, 8'h60);
      wr_reg(`PC_IDX_DRV_C, 8'hff);
      w(2);
      chk(pce, 8'h60);
      wr_reg(`PC_IDX_DRV_D, 8'hff);
      wr_reg(`PC_IDX_DIR_D, 8'hff);
      w(2);
      rd_reg(`PC_IDX_DRV_D, 8'h07);
      rd_reg(`PC_IDX_DIR_D, 8'h07);
      chk(sld, 3'h7);
      chk(pde, 3'h0);
      wr_reg(`PC_IDX_DIR_D, 8'h00);
      {ece, dfd, ptd, ecp, ecl} = {3'h7, 3'h7, 3'h5, 3'h3, 3'h6};
      w(2);
      chk(pdo, 3'h5);
      chk(pde, 3'h2);
      ecl = 3'h0;
      w(2);
      chk(pdo, 3'h3);
      {ece, dfd, xd, xde} = {3'h0, 3'h0, 3'h6, 3'h7};
      wr_reg(`PC_IDX_DIR_B, 8'h00);
      {xb, xbe, ickb, ickc} = {8'h3c, 8'hff, 8'hff, 8'hff};
      w(2);
      {ickb, ickc, xb} = {8'h00, 8'h00, 8'hc3};
      w(2);
      chk(imb, 8'h3c);
      chk(input_macrocell, 8'h60);
      chk(pdd, 3'h6);
      {cken, xd} = {1'b1, 3'h4};
      w(2);
      chk(mce, 1'b0);
      xd = 3'h6;
      w(1);
      chk(mce, 1'b1);
      w(3);
      chk(mce, 1'b0);
      csen = 1'b1;
      w(2);
      chk(stb, 1'b1);
      wr_reg(`PC_IDX_DRV_B, 8'h33);
      rd_reg(`PC_IDX_DRV_B, 8'h07);
      csen = 1'b0;
      w(2);
      chk(stb, 1'b0);
      rd_reg(`PC_IDX_DRV_B, 8'h00);
      summarize();
   end
endmodule : testbench
bind port_pin_direction_drive_control port_ctl_checker i_chk (.I_MCLK(I_MCLK),
   .I_RST_N(I_RST_N), .I_RD(I_RD), .I_CSI_EN(I_CSI_EN), .I_CLK_IN_EN(I_CLK_IN_EN),
   .O_MC_CLK_EN(O_MC_CLK_EN), .O_STANDBY(O_STANDBY), .O_RDATA(O_RDATA),
   .I_IMC_CLK_B(I_IMC_CLK_B), .I_PB_IN(I_PB_IN), .O_IMC_B(O_IMC_B),
   .I_B_SEL_FIRST(I_B_SEL_FIRST), .I_MC_FIRST(I_MC_FIRST), .O_PB_OUT(O_PB_OUT),
   .I_PD_IN(I_PD_IN), .O_PD_DIRECT(O_PD_DIRECT), .I_OE_DEF_D(I_OE_DEF_D),
   .I_OE_PT_D(I_OE_PT_D), .O_PD_OE_N(O_PD_OE_N), .I_ECS_PT(I_ECS_PT),
   .I_ECS_POL(I_ECS_POL), .I_ECS_EN(I_ECS_EN), .O_PD_OUT(O_PD_OUT));
